// >>> core/uifc_top.v
// Function
// - mask bit5 enables Xoff, enhanced-gated write
// - mask bit6 interrupts on RTS rising
// - mask bit7 interrupts on CTS rising
// - identification shows only highest pending source
// - codes for priority levels one to four
// - codes for levels five to eight, none
// - bit0 low while pending, high otherwise
// - line status from error bits, clears
// - timeout four chars plus twelve bits
// - receive ready follows receive trigger level
// - transmit ready from trigger or empty
// - transmit ready cleared by ident read or transmit holding write
// - modem and flow interrupts cleared by read
// - GPIO toggle interrupt, cleared by state read
// - Xoff sets bit4 until Xon; special char sets it until ident read
// - bit5 flow change, needs enhanced enable
// - bits 7:6 show FIFO enable
// - FIFO enable bit gates other bits
// - receive FIFO reset pulse, self clearing
// - transmit FIFO reset pulse, self clearing
// - bit3 selects DMA mode for pins
// - transmit trigger select, enhanced-gated write
// - receive trigger select
// - line interrupt held while errored chars remain
//
// Added by the designer: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "uifc_consts.vh"

module uifc_top (
    // Clock and reset
    input  wire        i_ref_clk,
    input  wire        i_rst,
    // AXI4-Lite slave
    input  wire [7:0]  i_awaddr,
    input  wire        i_awvalid,
    output reg         o_awready,
    input  wire [31:0] i_wdata,
    input  wire [3:0]  i_wstrb,
    input  wire        i_wvalid,
    output reg         o_wready,
    output reg  [1:0]  o_bresp,
    output reg         o_bvalid,
    input  wire        i_bready,
    input  wire [7:0]  i_araddr,
    input  wire        i_arvalid,
    output reg         o_arready,
    output reg  [31:0] o_rdata,
    output reg  [1:0]  o_rresp,
    output reg         o_rvalid,
    input  wire        i_rready,
    // Receive and transmit datapath status
    input  wire [6:0]  i_rx_level,
    input  wire [6:0]  i_tx_level,
    input  wire        i_tx_shift_empty,
    input  wire        i_half_duplex,
    input  wire [7:0]  i_line_status,
    input  wire        i_rx_char_done,
    input  wire        i_bit_tick,
    input  wire        i_xoff_seen,
    input  wire        i_xon_seen,
    input  wire        i_special_seen,
    input  wire [3:0]  i_modem_delta,
    // Pins
    input  wire        i_rts_pin,
    input  wire        i_cts_pin,
    input  wire [1:0]  i_gpio_pin,
    // Outputs to datapath and pins
    output reg         o_rx_fifo_reset,
    output reg         o_tx_fifo_reset,
    output reg         o_rx_read,
    output reg         o_tx_write,
    output reg  [7:0]  o_tx_data,
    output reg         o_fifo_enable,
    output reg         o_dma_mode,
    output reg         o_transmit_ready_pin_n,
    output reg         o_receive_ready_pin_n,
    output reg         o_irq
);

    // Synchronised pins
    wire       rts_s;
    wire       cts_s;
    wire [1:0] gpio_s;

    uifc_sync #(.W(4)) u_sync (
        .i_ref_clk (i_ref_clk),
        .i_rst     (i_rst),
        .i_async   ({i_gpio_pin, i_cts_pin, i_rts_pin}),
        .o_sync    ({gpio_s, cts_s, rts_s})
    );

    // Software state
    reg [7:0]  interrupt_mask_reg;
    reg        enhanced_reg;
    reg        fifo_en_reg;
    reg        dma_reg;
    reg [1:0]  tx_sel_reg;
    reg [1:0]  rx_sel_reg;
    // Pin history and sticky events
    reg        rts_d_reg;
    reg        cts_d_reg;
    reg [1:0]  gpio_d_reg;
    reg [1:0]  gpio_state_reg;
    reg        flow_reg;
    reg        modem_reg;
    reg        gpio_int_reg;
    reg        xoff_reg;
    reg        special_reg;
    reg        tx_int_reg;
    reg        tx_ready_d_reg;
    reg        timeout_reg;
    reg [7:0]  to_cnt_reg;
    // Bus state
    reg        aw_hold_reg;
    reg        w_hold_reg;
    reg [7:0]  aw_addr_reg;
    reg [31:0] w_data_reg;
    reg [3:0]  w_strb_reg;

    // Trigger decode
    reg [6:0] tx_trig;
    reg [6:0] rx_trig;
    always @* begin
        if (!fifo_en_reg) begin
            tx_trig = `UIFC_TRIG_DEFAULT;
            rx_trig = `UIFC_TRIG_DEFAULT;
        end else begin
            case (tx_sel_reg)
                2'h0:    tx_trig = `UIFC_TX_TRIG0;
                2'h1:    tx_trig = `UIFC_TX_TRIG1;
                2'h2:    tx_trig = `UIFC_TX_TRIG2;
                default: tx_trig = `UIFC_TX_TRIG3;
            endcase
            case (rx_sel_reg)
                2'h0:    rx_trig = `UIFC_RX_TRIG0;
                2'h1:    rx_trig = `UIFC_RX_TRIG1;
                2'h2:    rx_trig = `UIFC_RX_TRIG2;
                default: rx_trig = `UIFC_RX_TRIG3;
            endcase
        end
    end

    // Level-derived sources
    wire [6:0] tx_space   = `UIFC_FIFO_DEPTH - i_tx_level;
    wire       rx_int     = i_rx_level >= rx_trig;
    // Half-duplex waits for shifter too, so direction flips after last bit
    wire       tx_empty   = (i_tx_level == 7'h00) && (!i_half_duplex || i_tx_shift_empty);
    wire       tx_ready   = (tx_space >= tx_trig) || tx_empty;
    // Line status bit 7 stays set while errored characters remain
    wire       line_int   = |{i_line_status[7], i_line_status[4:1]};

    // Enabled pending sources, priority order
    wire p_line  = line_int && interrupt_mask_reg[`UIFC_MASK_LINE];
    wire p_to    = timeout_reg && interrupt_mask_reg[`UIFC_MASK_RECEIVE_READY_PIN_N];
    wire p_rx    = rx_int && interrupt_mask_reg[`UIFC_MASK_RECEIVE_READY_PIN_N];
    wire p_tx    = tx_int_reg && interrupt_mask_reg[`UIFC_MASK_TRANSMIT_READY_PIN_N];
    wire p_modem = modem_reg && interrupt_mask_reg[`UIFC_MASK_MODEM];
    wire p_gpio  = gpio_int_reg;
    wire p_xoff  = (xoff_reg || special_reg) && enhanced_reg;
    wire p_flow  = flow_reg && enhanced_reg;

    reg [5:0] ident_code;
    always @* begin
        if (p_line)       ident_code = `UIFC_ID_LINE;
        else if (p_to)    ident_code = `UIFC_ID_TIMEOUT;
        else if (p_rx)    ident_code = `UIFC_ID_RECEIVE_READY_PIN_N;
        else if (p_tx)    ident_code = `UIFC_ID_TRANSMIT_READY_PIN_N;
        else if (p_modem) ident_code = `UIFC_ID_MODEM;
        else if (p_gpio)  ident_code = `UIFC_ID_GPIO;
        else if (p_xoff)  ident_code = `UIFC_ID_XOFF;
        else if (p_flow)  ident_code = `UIFC_ID_FLOW;
        else              ident_code = `UIFC_ID_NONE;
    end
    wire [7:0] ident_value = {fifo_en_reg, fifo_en_reg, ident_code};

    // Write channel: address and data taken in either order
    wire [7:0]  wr_addr  = aw_hold_reg ? aw_addr_reg : i_awaddr;
    wire [31:0] wr_data  = w_hold_reg ? w_data_reg : i_wdata;
    wire [3:0]  wr_strb  = w_hold_reg ? w_strb_reg : i_wstrb;
    wire        aw_have  = aw_hold_reg || (i_awvalid && o_awready);
    wire        w_have   = w_hold_reg || (i_wvalid && o_wready);
    wire        wr_fire  = aw_have && w_have && !o_bvalid;
    wire        wr_lane0 = wr_fire && wr_strb[0];
    wire        rd_fire  = i_arvalid && o_arready;

    wire wr_mask   = wr_lane0 && (wr_addr == `UIFC_OFS_MASK);
    wire wr_fctl   = wr_lane0 && (wr_addr == `UIFC_OFS_FIFOCTL);
    wire wr_enh    = wr_lane0 && (wr_addr == `UIFC_OFS_ENHANCED);
    wire wr_tx     = wr_lane0 && (wr_addr == `UIFC_OFS_TXHOLD);
    wire rd_ident  = rd_fire && (i_araddr == `UIFC_OFS_IDENT);
    wire rd_rxhold = rd_fire && (i_araddr == `UIFC_OFS_RXHOLD);
    wire rd_modem  = rd_fire && (i_araddr == `UIFC_OFS_MODEM);
    wire rd_gpio   = rd_fire && (i_araddr == `UIFC_OFS_GPIO);
    wire wr_known  = (wr_addr == `UIFC_OFS_MASK) || (wr_addr == `UIFC_OFS_FIFOCTL)
                  || (wr_addr == `UIFC_OFS_ENHANCED) || (wr_addr == `UIFC_OFS_TXHOLD);

    reg [31:0] rd_value;
    reg        rd_ok;
    always @* begin
        rd_ok = 1'b1;
        case (i_araddr)
            `UIFC_OFS_MASK:     rd_value = {24'h000000, interrupt_mask_reg};
            `UIFC_OFS_IDENT:    rd_value = {24'h000000, ident_value};
            `UIFC_OFS_ENHANCED: rd_value = {31'h00000000, enhanced_reg};
            `UIFC_OFS_RXHOLD:   rd_value = 32'h00000000;
            `UIFC_OFS_MODEM:    rd_value = {28'h0000000, i_modem_delta};
            `UIFC_OFS_GPIO:     rd_value = {30'h00000000, gpio_s};
            `UIFC_OFS_STATUS:   rd_value = {16'h0000, 1'b0, i_rx_level, 1'b0, i_tx_level};
            default: begin
                rd_value = 32'h00000000;
                rd_ok    = 1'b0;
            end
        endcase
    end

    wire fctl_en = wr_data[`UIFC_FC_EN];

    always @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_awready          <= 1'b0;
            o_wready           <= 1'b0;
            o_bvalid           <= 1'b0;
            o_bresp            <= `UIFC_RESP_OKAY;
            o_arready          <= 1'b0;
            o_rvalid           <= 1'b0;
            o_rresp            <= `UIFC_RESP_OKAY;
            o_rdata            <= 32'h00000000;
            aw_hold_reg        <= 1'b0;
            w_hold_reg         <= 1'b0;
            aw_addr_reg        <= 8'h00;
            w_data_reg         <= 32'h00000000;
            w_strb_reg         <= 4'h0;
            interrupt_mask_reg <= 8'h00;
            enhanced_reg       <= 1'b0;
            fifo_en_reg        <= 1'b0;
            dma_reg            <= 1'b0;
            tx_sel_reg         <= 2'h0;
            rx_sel_reg         <= 2'h0;
            o_rx_fifo_reset    <= 1'b0;
            o_tx_fifo_reset    <= 1'b0;
            o_rx_read          <= 1'b0;
            o_tx_write         <= 1'b0;
            o_tx_data          <= 8'h00;
        end else begin
            // Bus handshakes
            o_awready <= !aw_have && !o_bvalid;
            o_wready  <= !w_have && !o_bvalid;
            if (i_awvalid && o_awready) begin
                aw_hold_reg <= 1'b1;
                aw_addr_reg <= i_awaddr;
            end
            if (i_wvalid && o_wready) begin
                w_hold_reg <= 1'b1;
                w_data_reg <= i_wdata;
                w_strb_reg <= i_wstrb;
            end
            if (wr_fire) begin
                aw_hold_reg <= 1'b0;
                w_hold_reg  <= 1'b0;
                o_awready   <= 1'b0;
                o_wready    <= 1'b0;
                o_bvalid    <= 1'b1;
                o_bresp     <= wr_known ? `UIFC_RESP_OKAY : `UIFC_RESP_SLVERR;
            end else if (o_bvalid && i_bready) begin
                o_bvalid <= 1'b0;
            end
            o_arready <= !o_rvalid && !o_arready;
            if (rd_fire) begin
                o_arready <= 1'b0;
                o_rvalid  <= 1'b1;
                o_rdata   <= rd_value;
                o_rresp   <= rd_ok ? `UIFC_RESP_OKAY : `UIFC_RESP_SLVERR;
            end else if (o_rvalid && i_rready) begin
                o_rvalid <= 1'b0;
            end
            // Register writes
            if (wr_enh)
                enhanced_reg <= wr_data[4];
            if (wr_mask) begin
                interrupt_mask_reg[3:0] <= wr_data[3:0];
                if (enhanced_reg)
                    interrupt_mask_reg[7:4] <= wr_data[7:4];
            end
            o_rx_fifo_reset <= wr_fctl && fctl_en && wr_data[`UIFC_FC_RXRST];
            o_tx_fifo_reset <= wr_fctl && fctl_en && wr_data[`UIFC_FC_TXRST];
            if (wr_fctl) begin
                fifo_en_reg <= fctl_en;
                if (fctl_en) begin
                    dma_reg    <= wr_data[`UIFC_FC_DMA];
                    rx_sel_reg <= wr_data[7:6];
                    if (enhanced_reg)
                        tx_sel_reg <= wr_data[5:4];
                end
            end
            o_rx_read  <= rd_rxhold;
            o_tx_write <= wr_tx;
            if (wr_tx)
                o_tx_data <= wr_data[7:0];
        end
    end

    // Interrupt sources; set wins over clear, except timeout, whose count a receive holding read restarts
    always @(posedge i_ref_clk) begin
        if (i_rst) begin
            rts_d_reg      <= 1'b0;
            cts_d_reg      <= 1'b0;
            gpio_d_reg     <= 2'h0;
            gpio_state_reg <= 2'h0;
            flow_reg       <= 1'b0;
            modem_reg      <= 1'b0;
            gpio_int_reg   <= 1'b0;
            xoff_reg       <= 1'b0;
            special_reg    <= 1'b0;
            tx_int_reg     <= 1'b0;
            tx_ready_d_reg <= 1'b0;
            timeout_reg    <= 1'b0;
            to_cnt_reg     <= 8'h00;
        end else begin
            rts_d_reg      <= rts_s;
            cts_d_reg      <= cts_s;
            gpio_d_reg     <= gpio_s;
            tx_ready_d_reg <= tx_ready;
            if (rd_gpio)
                gpio_state_reg <= gpio_s;
            if ((rts_s && !rts_d_reg && interrupt_mask_reg[`UIFC_MASK_RTS])
                || (cts_s && !cts_d_reg && interrupt_mask_reg[`UIFC_MASK_CTS]))
                flow_reg <= 1'b1;
            else if (rd_modem)
                flow_reg <= 1'b0;
            if (|i_modem_delta)
                modem_reg <= 1'b1;
            else if (rd_modem)
                modem_reg <= 1'b0;
            if (|(gpio_s ^ gpio_d_reg))
                gpio_int_reg <= 1'b1;
            else if (rd_gpio)
                gpio_int_reg <= 1'b0;
            if (i_xoff_seen && interrupt_mask_reg[`UIFC_MASK_XOFF])
                xoff_reg <= 1'b1;
            else if (i_xon_seen)
                xoff_reg <= 1'b0;
            if (i_special_seen && interrupt_mask_reg[`UIFC_MASK_XOFF])
                special_reg <= 1'b1;
            else if (rd_ident)
                special_reg <= 1'b0;
            // Only a fresh transmit-ready condition re-arms after a clear
            if (tx_ready && !tx_ready_d_reg)
                tx_int_reg <= 1'b1;
            else if (rd_ident || wr_tx || !tx_ready)
                tx_int_reg <= 1'b0;
            // Timer restarts on any received character or receive holding read
            if (i_rx_char_done || rd_rxhold || i_rx_level == 7'h00) begin
                to_cnt_reg <= 8'h00;
            end else if (i_bit_tick && to_cnt_reg != `UIFC_TO_BITS) begin
                to_cnt_reg <= to_cnt_reg + 8'h01;
                if (to_cnt_reg == `UIFC_TO_BITS - 8'h01)
                    timeout_reg <= 1'b1;
            end
            if (rd_rxhold && !(i_bit_tick && to_cnt_reg == `UIFC_TO_BITS - 8'h01))
                timeout_reg <= 1'b0;
        end
    end

    // Pins and interrupt output
    always @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_fifo_enable          <= 1'b0;
            o_dma_mode             <= 1'b0;
            o_transmit_ready_pin_n <= 1'b1;
            o_receive_ready_pin_n  <= 1'b1;
            o_irq                  <= 1'b0;
        end else begin
            o_fifo_enable <= fifo_en_reg;
            o_dma_mode    <= dma_reg;
            // DMA mode uses trigger levels; normal mode single character
            if (dma_reg) begin
                o_transmit_ready_pin_n <= !tx_ready;
                o_receive_ready_pin_n  <= !(rx_int || timeout_reg);
            end else begin
                o_transmit_ready_pin_n <= i_tx_level != 7'h00;
                o_receive_ready_pin_n  <= i_rx_level == 7'h00;
            end
            o_irq <= ident_code != `UIFC_ID_NONE;
        end
    end

endmodule // uifc_top

// >>> inc/uifc_consts.vh
`ifndef UIFC_CONSTS_VH
`define UIFC_CONSTS_VH

// Register byte offsets on the AXI4-Lite slave
`define UIFC_OFS_MASK      8'h00
`define UIFC_OFS_IDENT     8'h04
`define UIFC_OFS_FIFOCTL   8'h08
`define UIFC_OFS_ENHANCED  8'h0C
`define UIFC_OFS_RXHOLD    8'h10
`define UIFC_OFS_TXHOLD    8'h14
`define UIFC_OFS_MODEM     8'h18
`define UIFC_OFS_GPIO      8'h1C
`define UIFC_OFS_STATUS    8'h20

// Interrupt mask bit positions
`define UIFC_MASK_RECEIVE_READY_PIN_N    0
`define UIFC_MASK_TRANSMIT_READY_PIN_N    1
`define UIFC_MASK_LINE     2
`define UIFC_MASK_MODEM    3
`define UIFC_MASK_XOFF     5
`define UIFC_MASK_RTS      6
`define UIFC_MASK_CTS      7

// FIFO control bit positions
`define UIFC_FC_EN         0
`define UIFC_FC_RXRST      1
`define UIFC_FC_TXRST      2
`define UIFC_FC_DMA        3

// Identification codes, bits 5..0
`define UIFC_ID_LINE       6'h06
`define UIFC_ID_TIMEOUT    6'h0C
`define UIFC_ID_RECEIVE_READY_PIN_N      6'h04
`define UIFC_ID_TRANSMIT_READY_PIN_N      6'h02
`define UIFC_ID_MODEM      6'h00
`define UIFC_ID_GPIO       6'h30
`define UIFC_ID_XOFF       6'h10
`define UIFC_ID_FLOW       6'h20
`define UIFC_ID_NONE       6'h01

// Trigger levels
`define UIFC_TRIG_DEFAULT  7'h01
`define UIFC_TX_TRIG0      7'h08
`define UIFC_TX_TRIG1      7'h10
`define UIFC_TX_TRIG2      7'h20
`define UIFC_TX_TRIG3      7'h38
`define UIFC_RX_TRIG0      7'h08
`define UIFC_RX_TRIG1      7'h10
`define UIFC_RX_TRIG2      7'h38
`define UIFC_RX_TRIG3      7'h3C
`define UIFC_FIFO_DEPTH    7'h40

// Receive timeout: 4 characters plus 12 bits, in bit times
`define UIFC_CHAR_BITS     4'hA
`define UIFC_TO_BITS       8'h34

// AXI response codes
`define UIFC_RESP_OKAY     2'h0
`define UIFC_RESP_SLVERR   2'h2

`endif

// >>> core/uifc_sync.v
`timescale 1ns/1ps

module uifc_sync #(
    parameter W = 1
) (
    // Clock and reset
    input  wire         i_ref_clk,
    input  wire         i_rst,
    // Data
    input  wire [W-1:0] i_async,
    output wire [W-1:0] o_sync
);

    reg [W-1:0] meta_reg;
    reg [W-1:0] sync_reg;

    always @(posedge i_ref_clk) begin
        if (i_rst) begin
            meta_reg <= {W{1'b0}};
            sync_reg <= {W{1'b0}};
        end else begin
            meta_reg <= i_async;
            sync_reg <= meta_reg;
        end
    end

    assign o_sync = sync_reg;

endmodule // uifc_sync

// >>> sim/uifc_checker.sv
`timescale 1ns/1ps
`include "uifc_consts.vh"

module uifc_checker (
    // Clock and reset
    input wire        i_ref_clk,
    input wire        i_rst,
    // Read channel
    input wire [7:0]  i_araddr,
    input wire        i_arvalid,
    input wire        o_arready,
    input wire [31:0] o_rdata,
    input wire [1:0]  o_rresp,
    input wire        o_rvalid,
    // Datapath controls
    input wire        o_rx_fifo_reset,
    input wire        o_tx_fifo_reset,
    input wire        o_rx_read,
    input wire        o_fifo_enable
);
    logic [7:0] last_ar;

    // Address of the read under way, so read data can be judged by register
    always @(posedge i_ref_clk) begin
        if (i_rst) begin
            last_ar <= 8'hFF;
        end else if (i_arvalid && o_arready) begin
            last_ar <= i_araddr;
        end
    end

    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);

    a_rx_reset_pulse: assert property (
        o_rx_fifo_reset |=> !o_rx_fifo_reset) else $error("rx fifo reset held");
    a_tx_reset_pulse: assert property (
        o_tx_fifo_reset |=> !o_tx_fifo_reset) else $error("tx fifo reset held");
    a_rx_reset_gate: assert property (
        o_rx_fifo_reset |=> o_fifo_enable) else $error("rx fifo reset while disabled");
    a_tx_reset_gate: assert property (
        o_tx_fifo_reset |=> o_fifo_enable) else $error("tx fifo reset while disabled");
    a_ident_fifo_bits: assert property (
        o_rvalid && last_ar == `UIFC_OFS_IDENT |-> o_rdata[7:6] == {2{o_fifo_enable}})
        else $error("ident fifo bits wrong");
    a_ident_code_legal: assert property (
        o_rvalid && last_ar == `UIFC_OFS_IDENT |-> o_rdata[31:8] == 24'h0 &&
        o_rdata[5:0] inside {6'h06, 6'h0C, 6'h04, 6'h02, 6'h00, 6'h30, 6'h10, 6'h20, 6'h01})
        else $error("ident code not legal");
    a_fifoctl_write_only: assert property (
        o_rvalid && last_ar == `UIFC_OFS_FIFOCTL |-> o_rresp == `UIFC_RESP_SLVERR)
        else $error("fifo control read accepted");
    a_rx_read_cause: assert property (
        $rose(o_rx_read) |-> last_ar == `UIFC_OFS_RXHOLD ##1 !o_rx_read)
        else $error("rx read pulse without holding read");
endmodule // uifc_checker

bind uifc_top uifc_checker u_chk (.*);

// >>> sim/uifc_partner.sv
`timescale 1ns/1ps

module uifc_partner (
    // Clock
    input  wire        i_ref_clk,
    // Block side
    input  wire        i_rx_read,
    input  wire        i_tx_write,
    input  wire        i_rx_fifo_reset,
    input  wire        i_tx_fifo_reset,
    // Bench control
    input  wire        i_set,
    input  wire [6:0]  i_set_rx,
    input  wire [6:0]  i_set_tx,
    // Levels and bit timing
    output logic [6:0] o_rx_level,
    output logic [6:0] o_tx_level,
    output logic       o_bit_tick
);
    logic       link_clk = 1'b0;
    logic [2:0] link_q = 3'h0;

    // Offset start keeps the bit clock unrelated in phase to the reference
    initial begin
        #13;
        forever #40 link_clk = ~link_clk;
    end

    always @(posedge i_ref_clk) begin
        link_q <= {link_q[1:0], link_clk};
        o_bit_tick <= link_q[1] & ~link_q[2];
        if (i_set) begin
            o_rx_level <= i_set_rx;
            o_tx_level <= i_set_tx;
        end else begin
            if (i_rx_fifo_reset) o_rx_level <= 7'h00;
            else if (i_rx_read && o_rx_level != 7'h00) o_rx_level <= o_rx_level - 7'h01;
            // Full FIFO drops further writes
            if (i_tx_fifo_reset) o_tx_level <= 7'h00;
            else if (i_tx_write && o_tx_level != 7'h40) o_tx_level <= o_tx_level + 7'h01;
        end
    end
endmodule // uifc_partner

// >>> sim/uart_interrupt_fifo_control_tb_top.sv
`timescale 1ns/1ps
`include "uifc_consts.vh"

module uart_interrupt_fifo_control_tb_top;
    logic        clk = 1'b0, rst = 1'b1;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00, line_status = 8'h00;
    logic [31:0] wdata = 32'h0, rd_q;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic        xoff = 0, xon = 0, special = 0, rts = 0, cts = 0, set = 1;
    logic [3:0]  modem_delta = 4'h0;
    logic [1:0]  gpio = 2'h0, rresp_q;
    logic [6:0]  set_rx = 7'h00, set_tx = 7'h40;
    wire         awready, wready, bvalid, arready, rvalid, bit_tick, irq, txn, rxn;
    wire [7:0]   tx_data;
    wire         rx_rst, tx_rst, rx_read, tx_write, fifo_en, dma;
    wire [1:0]   bresp, rresp;
    wire [31:0]  rdata;
    wire [6:0]   rx_level, tx_level;
    int          fails = 0, comparisons = 0;
    int          trig [4] = '{8, 16, 56, 60};

    uifc_top DUT (
        .i_ref_clk(clk), .i_rst(rst), .i_awaddr(awaddr), .i_awvalid(awvalid),
        .o_awready(awready), .i_wdata(wdata), .i_wstrb(4'hF), .i_wvalid(wvalid),
        .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
        .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata),
        .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready), .i_rx_level(rx_level),
        .i_tx_level(tx_level), .i_tx_shift_empty(1'b1), .i_half_duplex(1'b0),
        .i_line_status(line_status), .i_rx_char_done(1'b0), .i_bit_tick(bit_tick),
        .i_xoff_seen(xoff), .i_xon_seen(xon), .i_special_seen(special),
        .i_modem_delta(modem_delta), .i_rts_pin(rts), .i_cts_pin(cts), .i_gpio_pin(gpio),
        .o_rx_fifo_reset(rx_rst), .o_tx_fifo_reset(tx_rst), .o_rx_read(rx_read),
        .o_tx_write(tx_write), .o_tx_data(tx_data), .o_fifo_enable(fifo_en), .o_dma_mode(dma),
        .o_transmit_ready_pin_n(txn), .o_receive_ready_pin_n(rxn), .o_irq(irq)
    );

    uifc_partner u_far (
        .i_ref_clk(clk), .i_rx_read(rx_read), .i_tx_write(tx_write),
        .i_rx_fifo_reset(rx_rst), .i_tx_fifo_reset(tx_rst), .i_set(set),
        .i_set_rx(set_rx), .i_set_tx(set_tx), .o_rx_level(rx_level),
        .o_tx_level(tx_level), .o_bit_tick(bit_tick)
    );

    always #2.5 clk = ~clk;

    task automatic stop_test;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic settle;
        repeat (6) @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic done = 1'b0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!done) begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            done = bvalid;
        end
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        logic done = 1'b0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!done) begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            done = rvalid;
        end
        rd_q = rdata;
        rresp_q = rresp;
        rready <= 1'b0;
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] exp);
        rd(a);
        chk(rd_q, exp);
    endtask

    task automatic ri(input logic [31:0] e);
        rc(`UIFC_OFS_IDENT, e);
    endtask

    task automatic setlv(input logic [6:0] r, input logic [6:0] t);
        @(posedge clk);
        set <= 1'b1;
        set_rx <= r;
        set_tx <= t;
        @(posedge clk);
        set <= 1'b0;
        settle;
    endtask

    task automatic pulse(input int k);
        @(posedge clk);
        if (k == 0) xoff <= 1'b1; else if (k == 1) xon <= 1'b1; else special <= 1'b1;
        @(posedge clk);
        xoff <= 1'b0;
        xon <= 1'b0;
        special <= 1'b0;
        settle;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        stop_test;
    end

    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        set <= 1'b0;
        ri(32'h01);
        rc(`UIFC_OFS_MASK, 32'h00);
        rc(`UIFC_OFS_STATUS, 32'h40);
        rd(8'h40);
        chk(rresp_q, `UIFC_RESP_SLVERR);
        rd(`UIFC_OFS_FIFOCTL);
        chk(rresp_q, `UIFC_RESP_SLVERR);
        wr(`UIFC_OFS_MASK, 32'hFF);
        rc(`UIFC_OFS_MASK, 32'h0F);
        wr(`UIFC_OFS_ENHANCED, 32'h10);
        wr(`UIFC_OFS_MASK, 32'hFF);
        rc(`UIFC_OFS_MASK, 32'hFF);
        ri(32'h01);
        wr(`UIFC_OFS_FIFOCTL, 32'h09);
        settle;
        chk({fifo_en, dma}, 32'h3);
        ri(32'hC1);
        wr(`UIFC_OFS_FIFOCTL, 32'h08);
        settle;
        chk({fifo_en, dma}, 32'h1);
        wr(`UIFC_OFS_FIFOCTL, 32'h01);
        settle;
        chk({fifo_en, dma}, 32'h2);
        setlv(7'h05, 7'h40);
        wr(`UIFC_OFS_FIFOCTL, 32'h03);
        rc(`UIFC_OFS_STATUS, 32'h40);
        setlv(7'h05, 7'h0A);
        wr(`UIFC_OFS_FIFOCTL, 32'h05);
        settle;
        chk(irq, 32'h1);
        rc(`UIFC_OFS_STATUS, 32'h500);
        ri(32'hC2);
        ri(32'hC1);
        settle;
        chk(irq, 32'h0);
        setlv(7'h00, 7'h40);
        setlv(7'h00, 7'h00);
        wr(`UIFC_OFS_TXHOLD, 32'h41);
        settle;
        chk(tx_data, 32'h41);
        rc(`UIFC_OFS_STATUS, 32'h01);
        ri(32'hC1);
        for (int c = 0; c < 4; c++) begin
            wr(`UIFC_OFS_FIFOCTL, {24'h0, c[1:0], 6'h01});
            setlv(7'(trig[c] - 1), 7'h01);
            ri(32'hC1);
            setlv(7'(trig[c]), 7'h01);
            ri(32'hC4);
            rd(`UIFC_OFS_RXHOLD);
            settle;
            ri(32'hC1);
        end
        wr(`UIFC_OFS_FIFOCTL, 32'h01);
        setlv(7'h08, 7'h01);
        line_status <= 8'h80;
        settle;
        ri(32'hC6);
        ri(32'hC6);
        line_status <= 8'h00;
        settle;
        ri(32'hC4);
        setlv(7'h00, 7'h01);
        modem_delta <= 4'h1;
        settle;
        modem_delta <= 4'h0;
        ri(32'hC0);
        rd(`UIFC_OFS_MODEM);
        ri(32'hC1);
        pulse(0);
        ri(32'hD0);
        ri(32'hD0);
        pulse(1);
        ri(32'hC1);
        pulse(2);
        ri(32'hD0);
        ri(32'hC1);
        gpio <= 2'h1;
        settle;
        ri(32'hF0);
        rd(`UIFC_OFS_GPIO);
        ri(32'hC1);
        cts <= 1'b1;
        settle;
        ri(32'hE0);
        rd(`UIFC_OFS_MODEM);
        ri(32'hC1);
        rts <= 1'b1;
        settle;
        ri(32'hE0);
        rd(`UIFC_OFS_MODEM);
        wr(`UIFC_OFS_ENHANCED, 32'h00);
        cts <= 1'b0;
        settle;
        cts <= 1'b1;
        settle;
        ri(32'hC1);
        // One idle character, long enough for the timeout
        setlv(7'h01, 7'h01);
        repeat (1000) @(posedge clk);
        ri(32'hCC);
        chk({txn, rxn}, 32'h2);
        rd(`UIFC_OFS_RXHOLD);
        settle;
        ri(32'hC1);
        stop_test;
    end
endmodule // uart_interrupt_fifo_control_tb_top
